// ===== tdm_pkg.sv
// Purpose: Shared constants for the die thermal monitor
// Assumes: pclk at 100 MHz; all times are turned into cycles here
// Notes:   Register offsets are byte addresses on the APB slave
package tdm_pkg;
    // Clock
    localparam int unsigned CLK_PERIOD_NS = 10;

    // Six warning thresholds: 80, 95, 110, 125, 140 and 155 degrees C
    localparam int unsigned NUM_THR = 6;

    // Debounce time, least time, so round up
    localparam int unsigned DB_TIME_NS = 10_000;
    localparam int unsigned DB_CYC     = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DB_W       = 10;

    // Sampling window and interval, in us
    localparam int unsigned WINDOW_US   = 450;
    localparam int unsigned INTERVAL_US = 3_000;
    localparam int unsigned WINDOW_CYC   = (WINDOW_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned INTERVAL_CYC = (INTERVAL_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned SMP_W        = 20;

    // Register offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_EVENT = 8'h04;
    localparam logic [7:0] OFS_LIVE  = 8'h08;
    localparam logic [7:0] OFS_MASK  = 8'h0C;

    // Control field positions
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_AON_BIT = 1;
    // Live register: shutdown and power flags sit above the levels
    localparam int unsigned LIVE_SD_BIT  = 8;
    localparam int unsigned LIVE_PWR_BIT = 9;

    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam logic [5:0] MASK_RST = 6'h3F;
endpackage

// ===== tdm_watch_if.sv
// Purpose: Carries the sensor power state from the sampler to the core
// Assumes: One clock domain
// Notes:   monitor_on is registered in the sampler
`timescale 1ns/1ps
interface tdm_watch_if;
    logic monitor_on;  // Sensor and comparators powered
    modport src (output monitor_on);
    modport dst (input  monitor_on);
endinterface

// ===== tdm_debounce.sv
// Purpose: One comparator debouncer, both directions
// Assumes: Raw input synchronous to pclk
// Notes:   Freezes while the sensor is unpowered, so stale levels never flip it
`timescale 1ns/1ps
module tdm_debounce (
    input  wire logic pclk,     // Clock
    input  wire logic presetn,  // Async reset, low
    input  wire logic active,   // Sensor powered
    input  wire logic raw,      // Comparator output
    output logic      stable    // Debounced level
);
    logic [tdm_pkg::DB_W-1:0] cnt;  // Cycles raw has disagreed
    wire differ  = active && (raw != stable);
    wire at_last = (cnt == tdm_pkg::DB_W'(tdm_pkg::DB_CYC - 1));

    // Count disagreement; any agreement or power loss restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt    <= '0;
            stable <= 1'b0;
        end else if (differ && at_last) begin
            cnt    <= '0;
            stable <= raw;
        end else if (differ) begin
            cnt    <= cnt + 1'b1;
        end else begin
            cnt    <= '0;
        end
    end

    sequence s_flip;
        differ && at_last;
    endsequence

    a_debounce_flip: assert property (@(posedge pclk) disable iff (!presetn)
        s_flip |=> (stable == $past(raw)))
        else $error("debounced level did not follow raw");
    a_debounce_early: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(stable) |-> $past(cnt) == tdm_pkg::DB_W'(tdm_pkg::DB_CYC - 1))
        else $error("debounced level changed before full count");
endmodule

// ===== tdm_sampler.sv
// Purpose: Decides when the thermal sensor is powered
// Assumes: Enable and mode bits come from the register block
// Notes:   Standby forces sampling even with always-on set
`timescale 1ns/1ps
module tdm_sampler #(
    parameter int unsigned WINDOW   = tdm_pkg::WINDOW_CYC,   // Window cycles
    parameter int unsigned INTERVAL = tdm_pkg::INTERVAL_CYC  // Period cycles
) (
    input  wire logic   pclk,       // Clock
    input  wire logic   presetn,    // Async reset, low
    input  wire logic   enable,     // Monitoring enabled
    input  wire logic   always_on,  // Continuous mode request
    input  wire logic   standby,    // Device in standby
    tdm_watch_if.src    watch       // Power state out
);
    logic [tdm_pkg::SMP_W-1:0] cnt;  // Position in the sampling period
    wire continuous  = always_on && !standby;
    wire period_end  = (cnt == tdm_pkg::SMP_W'(INTERVAL - 1));
    wire in_window   = (cnt < tdm_pkg::SMP_W'(WINDOW));
    wire next_on     = enable && (continuous || in_window);

    // Free-running period counter, parked while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (!enable || period_end) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // Registered power output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watch.monitor_on <= 1'b0;
        end else begin
            watch.monitor_on <= next_on;
        end
    end

    a_disable_off: assert property (@(posedge pclk) disable iff (!presetn)
        !enable |=> !watch.monitor_on)
        else $error("monitor powered while disabled");
    a_aon_run: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && always_on && !standby) |=> watch.monitor_on)
        else $error("always-on mode not continuous");
    a_window_close: assert property (@(posedge pclk) disable iff (!presetn)
        (enable && !continuous && cnt == tdm_pkg::SMP_W'(WINDOW)) |=> !watch.monitor_on)
        else $error("sampling window not closed on time");
endmodule

// ===== tdm_monitor.sv
// Purpose: Die thermal monitor digital control with APB registers
// Assumes: Comparator inputs come from the die centre sensor only
// Notes:   Register map below; event bits are write-one-to-clear
// Map: 0x00 CTRL  bit0 heat_watch_enable, bit1 heat_watch_always_on
//      0x04 EVENT bits5:0 hot_event_latch, write one clears
//      0x08 LIVE  bits5:0 hot_live_level, bit8 shutdown, bit9 powered
//      0x0C MASK  bits5:0 hot_event_mask, one masks
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tdm_monitor #(
    parameter int unsigned WINDOW   = tdm_pkg::WINDOW_CYC,   // Window cycles
    parameter int unsigned INTERVAL = tdm_pkg::INTERVAL_CYC  // Period cycles
) (
    input  wire logic        pclk,          // Clock, 100 MHz
    input  wire logic        presetn,       // Async reset, low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB write
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        standby,       // Device in standby state
    input  wire logic [5:0]  trip_above,    // Centre sensor above threshold
    input  wire logic [5:0]  rel_above,     // Centre sensor above threshold less 5 C
    input  wire logic        sd_above,      // Centre sensor above shutdown
    input  wire logic        sd_rel_above,  // Above shutdown less hysteresis
    output logic             monitor_on,    // Sensor power request
    output logic             thermal_shdn,  // Thermal shutdown active
    output logic             irq_out_n      // Interrupt, low active
);
    localparam int unsigned N = tdm_pkg::NUM_THR;

    // Control and status storage
    logic         heat_watch_enable;     // Monitoring on
    logic         heat_watch_always_on;  // Continuous mode in run
    logic [N-1:0] hot_event_mask;        // One blocks the interrupt
    logic [N-1:0] hot_event_latch;       // Sticky crossing flags
    logic [N-1:0] hot_live_level;        // Live levels with hysteresis

    // Debounced comparator levels: trip, release, shutdown pair
    logic [2*N+1:0] raw_cmp;
    logic [2*N+1:0] deb_cmp;
    wire  [N-1:0]   deb_trip   = deb_cmp[N-1:0];
    wire  [N-1:0]   deb_rel    = deb_cmp[2*N-1:N];
    wire            deb_sd     = deb_cmp[2*N];
    wire            deb_sd_rel = deb_cmp[2*N+1];

    // Only the centre sensor's comparators enter here
    assign raw_cmp = {sd_rel_above, sd_above, rel_above, trip_above};

    // Sensor power scheduling
    tdm_watch_if watch ();

    tdm_sampler #(
        .WINDOW   (WINDOW),
        .INTERVAL (INTERVAL)
    ) u_sampler (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (heat_watch_enable),
        .always_on (heat_watch_always_on),
        .standby   (standby),
        .watch     (watch)
    );

    assign monitor_on = watch.monitor_on;

    // One debouncer per comparator, all timed by pclk
    genvar gi;
    generate
        for (gi = 0; gi < 2*N+2; gi++) begin : g_db
            tdm_debounce u_db (
                .pclk    (pclk),
                .presetn (presetn),
                .active  (watch.monitor_on),
                .raw     (raw_cmp[gi]),
                .stable  (deb_cmp[gi])
            );
        end
    endgenerate

    // APB decode
    wire setup_ph  = psel && !penable;
    wire access_ph = psel && penable;
    wire hit_ctrl  = (paddr == tdm_pkg::OFS_CTRL);
    wire hit_event = (paddr == tdm_pkg::OFS_EVENT);
    wire hit_live  = (paddr == tdm_pkg::OFS_LIVE);
    wire hit_mask  = (paddr == tdm_pkg::OFS_MASK);
    wire mapped    = hit_ctrl || hit_event || hit_live || hit_mask;
    wire wr_en     = access_ph && pwrite && mapped;

    // Write-one-to-clear vector for the event flags
    wire [N-1:0] evt_clr = (wr_en && hit_event) ? pwdata[N-1:0] : '0;

    // Zero wait states; errors only on unmapped addresses
    assign pready  = 1'b1;
    assign pslverr = access_ph && !mapped;

    // Read mux, sampled into prdata during setup
    wire [31:0] rd_ctrl  = {30'h0, heat_watch_always_on, heat_watch_enable};
    wire [31:0] rd_event = {26'h0, hot_event_latch};
    wire [31:0] rd_live  = {22'h0, watch.monitor_on, thermal_shdn, 2'h0, hot_live_level};
    wire [31:0] rd_mask  = {26'h0, hot_event_mask};
    wire [31:0] next_prdata = hit_ctrl  ? rd_ctrl  :
                              hit_event ? rd_event :
                              hit_live  ? rd_live  :
                              hit_mask  ? rd_mask  : 32'h0000_0000;

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= next_prdata;
        end
    end

    // Control register: enable and always-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heat_watch_enable    <= tdm_pkg::CTRL_RST[tdm_pkg::CTRL_EN_BIT];
            heat_watch_always_on <= tdm_pkg::CTRL_RST[tdm_pkg::CTRL_AON_BIT];
        end else if (wr_en && hit_ctrl) begin
            heat_watch_enable    <= pwdata[tdm_pkg::CTRL_EN_BIT];
            heat_watch_always_on <= pwdata[tdm_pkg::CTRL_AON_BIT];
        end
    end

    // Mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_event_mask <= tdm_pkg::MASK_RST;
        end else if (wr_en && hit_mask) begin
            hot_event_mask <= pwdata[N-1:0];
        end
    end

    // Live levels: set on debounced trip, drop below release point
    // Disabling monitoring clears them, since nothing is watched then
    wire [N-1:0] next_live = !heat_watch_enable ? '0 :
                             (deb_trip | (hot_live_level & deb_rel));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_live_level <= '0;
        end else begin
            hot_live_level <= next_live;
        end
    end

    // Rising level sets the flag; a set beats a same-cycle clear
    wire [N-1:0] evt_set = next_live & ~hot_live_level;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_event_latch <= '0;
        end else begin
            hot_event_latch <= (hot_event_latch & ~evt_clr) | evt_set;
        end
    end

    // Shutdown: trips on debounced 165 C, released only once cooled
    // Held across a disable so a hot die is never re-enabled early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thermal_shdn <= 1'b0;
        end else if (heat_watch_enable && deb_sd) begin
            thermal_shdn <= 1'b1;
        end else if (watch.monitor_on && !deb_sd_rel) begin
            thermal_shdn <= 1'b0;
        end
    end

    // Interrupt: any unmasked latched flag pulls it low
    assign irq_out_n = ~|(hot_event_latch & ~hot_event_mask);

    sequence s_level_rise;
        $rose(hot_live_level[0]);
    endsequence

    sequence s_trip_seen;
        $past(deb_trip[0]);
    endsequence

    a_latch_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
        ((hot_live_level & ~$past(hot_live_level)) & ~hot_event_latch) == '0)
        else $error("rising level did not set event flag");
    a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
        ((($past(hot_event_latch) & ~$past(evt_clr)) & ~hot_event_latch) == '0))
        else $error("event flag dropped without a clear");
    a_irq_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(hot_event_latch[0]) && !hot_event_mask[0]) |-> !irq_out_n)
        else $error("unmasked event did not raise interrupt");
    a_level_cause: assert property (@(posedge pclk) disable iff (!presetn)
        s_level_rise |-> s_trip_seen)
        else $error("live level rose without debounced trip");
    a_level_release: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(hot_live_level[0]) |-> $past(!deb_rel[0] || !heat_watch_enable))
        else $error("live level released above release point");
    a_shdn_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (thermal_shdn && deb_sd_rel) |=> thermal_shdn)
        else $error("shutdown released before cooling");
    a_shdn_trip: assert property (@(posedge pclk) disable iff (!presetn)
        (heat_watch_enable && deb_sd) |=> thermal_shdn)
        else $error("shutdown not started at threshold");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (access_ph && !mapped) |-> (pslverr && pready))
        else $error("unmapped access not flagged");
endmodule

// ===== tdm_sense_model.sv
// Purpose: Centre-die comparator bank seen by the monitor
// Assumes: Temperature in whole degrees C
// Notes:   Unpowered outputs toggle, so a stale level is never trusted
`timescale 1ns/1ps
module tdm_sense_model (
    input  wire logic       pclk,          // Clock
    input  wire logic       monitor_on,    // Sensor powered
    input  var int          temp,          // Centre temperature, C
    output logic      [5:0] trip_above,    // Above threshold
    output logic      [5:0] rel_above,     // Above threshold less 5 C
    output logic            sd_above,      // Above shutdown
    output logic            sd_rel_above   // Above shutdown less 15 C
);
    logic flip = 1'b0;  // Junk level while unpowered

    // Toggle every cycle, used only when the sensor is off
    always @(posedge pclk) flip <= ~flip;

    // One sensor feeds every comparator
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            trip_above[i] = monitor_on ? (temp > 80 + 15 * i) : flip;
            rel_above[i]  = monitor_on ? (temp > 75 + 15 * i) : ~flip;
        end
        sd_above     = monitor_on ? (temp > 165) : flip;
        sd_rel_above = monitor_on ? (temp > 150) : ~flip;
    end
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the thermal monitor
// Assumes: Debounce is 1000 cycles; window and period shortened
// Notes:   Fixed waits come from the debounce figure plus margin
`timescale 1ns/1ps
module testbench;
    localparam int unsigned WIN = 1100;  // Window, above debounce
    localparam int unsigned PER = 1500;  // Sampling period
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, standby = 0;
    logic [7:0]  paddr = 0;           // APB address
    logic [31:0] pwdata = 0, prdata;  // APB data
    logic        pready, pslverr, sd_above, sd_rel_above, monitor_on, thermal_shdn, irq_out_n;
    logic [5:0]  trip_above, rel_above;  // Comparator levels
    logic [31:0] seed = 32'h0000_22c1, rd;  // Random state, read data
    logic        er;                        // Read error
    int temp = 20, error_cnt = 0, checked = 0, cnt, i, m;
    int exp_live = 0, exp_latch = 0, exp_mask = 63, exp_sd = 0;  // Bench model

    always #5 pclk = ~pclk;

    tdm_monitor #(.WINDOW(WIN), .INTERVAL(PER)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
        .trip_above(trip_above), .rel_above(rel_above), .sd_above(sd_above),
        .sd_rel_above(sd_rel_above), .monitor_on(monitor_on), .thermal_shdn(thermal_shdn),
        .irq_out_n(irq_out_n));
    tdm_sense_model u_model (.pclk(pclk), .monitor_on(monitor_on), .temp(temp),
        .trip_above(trip_above), .rel_above(rel_above), .sd_above(sd_above),
        .sd_rel_above(sd_rel_above));

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Verdict, the one exit
    task end_sim();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        if (n == 16) begin
            error_cnt++;
            end_sim();
        end
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0000_0000);
        chk_reg(rd, exp);
    endtask

    // New temperature, wait out debounce, compare with model
    task set_temp(input int t);
        temp <= t;
        repeat (1010) @(posedge pclk);
        for (int k = 0; k < 6; k++) begin
            if (t > 80 + 15 * k) begin
                exp_live  |= 1 << k;
                exp_latch |= 1 << k;
            end else if (t <= 75 + 15 * k)
                exp_live &= ~(1 << k);
        end
        if (t > 165) exp_sd = 1; else if (t <= 150) exp_sd = 0;
        rd_chk(tdm_pkg::OFS_LIVE, 32'(exp_live | exp_sd << 8 | 512));
        rd_chk(tdm_pkg::OFS_EVENT, 32'(exp_latch));
        chk_pin(thermal_shdn, exp_sd[0]);
        chk_pin(irq_out_n, (exp_latch & ~exp_mask & 63) == 0);
    endtask

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        // Reset values, unmapped and read-only places
        rd_chk(tdm_pkg::OFS_CTRL, 32'h0000_0003);
        rd_chk(tdm_pkg::OFS_MASK, 32'h0000_003F);
        rd_chk(tdm_pkg::OFS_EVENT, 32'h0000_0000);
        apb(1, 8'h10, 32'hFFFF_FFFF);
        chk_pin(er, 1'b1);
        apb(1, tdm_pkg::OFS_LIVE, 32'hFFFF_FFFF);
        rd_chk(tdm_pkg::OFS_LIVE, 32'h0000_0200);
        $display("test registers done");
        // Short spike must be ignored
        temp <= 130;
        repeat (500) @(posedge pclk);
        set_temp(20);
        $display("test glitch done");
        // Rising, hysteresis, then random temperatures and masks
        exp_mask = 0;
        apb(1, tdm_pkg::OFS_MASK, 32'h0000_0000);
        set_temp(96);
        set_temp(93);
        set_temp(89);
        for (i = 0; i < 3; i++) begin
            exp_mask = int'(rnd() & 63);
            apb(1, tdm_pkg::OFS_MASK, 32'(exp_mask));
            set_temp(70 + int'(rnd() % 90));
        end
        // Write one to clear, part then whole
        set_temp(20);
        apb(1, tdm_pkg::OFS_EVENT, 32'h0000_0015);
        exp_latch &= ~21;
        rd_chk(tdm_pkg::OFS_EVENT, 32'(exp_latch));
        apb(1, tdm_pkg::OFS_EVENT, 32'h0000_003F);
        exp_latch = 0;
        set_temp(20);
        $display("test events done");
        // Shutdown holds through 155, drops below 150
        set_temp(170);
        set_temp(155);
        set_temp(149);
        $display("test shutdown done");
        // Power modes: off, sampling, standby sampling, always on
        for (m = 0; m < 4; m++) begin
            apb(1, tdm_pkg::OFS_CTRL, m == 0 ? 32'h0000_0000 : m == 1 ? 32'h0000_0001
                                              : 32'h0000_0003);
            standby <= (m == 2);
            repeat (PER) @(posedge pclk);
            cnt = 0;
            for (i = 0; i < PER; i++) begin
                @(negedge pclk);
                cnt += int'(monitor_on);
            end
            chk_reg(32'(cnt), m == 0 ? 0 : m == 3 ? PER : WIN);
            if (m == 0) rd_chk(tdm_pkg::OFS_LIVE, 32'h0000_0000);
        end
        $display("test power modes done");
        end_sim();
    end
endmodule
